// File: core/via_pkg.sv
// Constants, types and state layout of the vectored interrupt arbiter.
// Function
// - Every accepted interrupt loads the program counter with entry address 00FF.
// - Software trap ranks highest; default vector-select entry ranks lowest.
// - Thirteen maskable inputs, each with a fixed rank and own vector slot.
// - All but the trap are maskable, each with pending flag and enable bit.
// - Maskable request needs its enable, global enable, and no trap in service.
// - Requests are judged at instruction start; only the top-ranked one is taken.
// - Reset clears all pending flags, enable bits and the global enable.
// - A flag already pending fires as soon as its enable is set.
// - Acknowledge only at a normal instruction start; a pending skip goes first.
// - Acknowledge clears global enable, pushes next address, loads 00FF.
// - The acknowledge sequence lasts seven instruction cycles.
// - Return instruction sets the global enable and reloads the popped address.
// - After return any qualifying pending request is taken at once.
// - Vector-select finds the top enabled pending request and jumps through its vector.
// - Vector table sits atop the vector-select block, or the next block at byte FF.
// - Each vector is a 15-bit address, high byte at the lower address.
// - Lowest vector at 0yE0/0yE1, two bytes per rank, trap at 0yFE/0yFF.
// - With nothing enabled and pending, vector-select uses the default vector.
// - Vector-select yields an even byte E0..FE replacing the low program counter byte.
// - Trap pending flag: set by trap, cleared by reset and clear-trap instruction, unmapped.
// - Fetching the trap instruction raises the non-maskable software trap.
package via_pkg;

    localparam int          NUM_SRC       = 13;
    localparam int          CLK_NS        = 10;
    localparam int          INSTR_CYC_NS  = 100;
    localparam int          INSTR_CLKS    = (INSTR_CYC_NS + CLK_NS - 1) / CLK_NS;
    localparam int          ACK_INSTR_CYC = 7;
    localparam int          ACK_CLKS      = ACK_INSTR_CYC * INSTR_CLKS;
    localparam logic [14:0] ENTRY_ADDR    = 15'h00ff;
    localparam logic [7:0]  VEC_BASE      = 8'he0;
    localparam logic [3:0]  SLOT_DEFAULT  = 4'h0;
    localparam logic [3:0]  SLOT_TRAP     = 4'hf;
    localparam logic [7:0]  BLOCK_LAST    = 8'hff;

    localparam logic [7:0]  OFS_PEND      = 8'h00;
    localparam logic [7:0]  OFS_EN        = 8'h04;
    localparam logic [7:0]  OFS_CTRL      = 8'h08;
    localparam int          CTRL_GIE_BIT  = 0;
    localparam int          CTRL_BUSY_BIT = 1;
    localparam logic [12:0] PEND_RST      = 13'h0000;
    localparam logic [12:0] EN_RST        = 13'h0000;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    typedef enum logic [1:0] {
        VIA_IDLE = 2'b01,
        VIA_ACK  = 2'b10
    } via_st_t;

    typedef struct packed {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } via_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } via_axi_rsp_t;

    typedef struct packed {
        via_st_t      st;
        logic [12:0]  pend;
        logic [12:0]  en;
        logic         global_int_enable;
        logic         trap_pend;
        logic         trap_req;
        logic [3:0]   div;
        logic [2:0]   acks;
        logic         push;
        logic [14:0]  push_addr;
        logic         pc_load;
        logic [14:0]  pc_addr;
        logic         vis_valid;
        logic [7:0]   vis_low;
        logic [14:0]  vis_addr;
        logic         aw_got;
        logic         w_got;
        logic [7:0]   awaddr;
        logic [31:0]  wdata;
        logic [3:0]   wstrb;
        via_axi_rsp_t axi;
    } via_state_t;

endpackage : via_pkg

// File: core/via_core.sv
// Interrupt pending, masking, ranking, acknowledge and vector-select logic.
//
// The register addresses and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/10ps
module via_core (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire via_pkg::via_axi_req_t axi_i,
    output via_pkg::via_axi_rsp_t     axi_o,
    input  wire logic [12:0]          src_event_i,
    input  wire logic                 trap_fetch_i,
    input  wire logic                 clear_trap_i,
    input  wire logic                 instr_start_i,
    input  wire logic                 skip_i,
    input  wire logic [14:0]          next_pc_i,
    input  wire logic                 return_from_int_instr_i,
    input  wire logic [14:0]          pop_addr_i,
    input  wire logic                 vis_exec_i,
    input  wire logic [14:0]          vis_pc_i,
    output logic                      ack_busy_o,
    output logic                      gie_o,
    output logic                      push_o,
    output logic [14:0]               push_addr_o,
    output logic                      pc_load_o,
    output logic [14:0]               pc_addr_o,
    output logic                      vis_valid_o,
    output logic [7:0]                vis_low_o,
    output logic [14:0]               vis_addr_o
);
    import via_pkg::*;

    via_state_t q;
    via_state_t d;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [12:0] lane_mask(input logic [3:0] strb);
        lane_mask = {{5{strb[1]}}, {8{strb[0]}}};
    endfunction : lane_mask

    // Highest set bit wins; maskable source k owns slot k+1.
    function automatic logic [3:0] top_slot(input logic [12:0] act);
        top_slot = SLOT_DEFAULT;
        for (int k = 0; k < NUM_SRC; k++) begin
            if (act[k]) begin
                top_slot = 4'(k + 1);
            end
        end
    endfunction : top_slot

    logic [12:0] active;
    logic        mask_ok;
    logic        accept;
    logic        tick;
    logic [3:0]  slot;
    logic [6:0]  vis_blk;
    logic        wr_go;
    logic [12:0] wmask;

    assign active  = q.pend & q.en;
    assign mask_ok = q.global_int_enable & ~q.trap_pend & (|active);
    assign accept  = (q.st == VIA_IDLE) & instr_start_i & ~skip_i & ~return_from_int_instr_i
                     & (q.trap_req | mask_ok);
    assign tick    = (q.div == 4'(INSTR_CLKS - 1));
    assign wr_go   = q.aw_got & q.w_got & ~q.axi.bvalid;
    assign wmask   = lane_mask(q.wstrb);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        d           = q;
        d.push      = 1'b0;
        d.pc_load   = 1'b0;
        d.vis_valid = 1'b0;
        slot        = SLOT_DEFAULT;
        vis_blk     = 7'h00;

        // Events set pending flags; a set in the same cycle beats a clear.
        d.pend = q.pend;
        if (wr_go && q.awaddr == OFS_PEND) begin
            d.pend = q.pend & ~(q.wdata[12:0] & wmask);
        end
        d.pend = d.pend | src_event_i;

        if (clear_trap_i) begin
            d.trap_pend = 1'b0;
        end
        if (trap_fetch_i) begin
            d.trap_pend = 1'b1;
            d.trap_req  = 1'b1;
        end

        // AXI4-Lite write channel.
        if (axi_i.awvalid && q.axi.awready) begin
            d.aw_got = 1'b1;
            d.awaddr = axi_i.awaddr;
        end
        if (axi_i.wvalid && q.axi.wready) begin
            d.w_got = 1'b1;
            d.wdata = axi_i.wdata;
            d.wstrb = axi_i.wstrb;
        end
        if (wr_go) begin
            d.aw_got     = 1'b0;
            d.w_got      = 1'b0;
            d.axi.bvalid = 1'b1;
            d.axi.bresp  = RESP_OKAY;
            unique case (q.awaddr)
                OFS_PEND: ;
                OFS_EN: d.en = (q.en & ~wmask) | (q.wdata[12:0] & wmask);
                OFS_CTRL: begin
                    if (q.wstrb[0]) begin
                        d.global_int_enable = q.wdata[CTRL_GIE_BIT];
                    end
                end
                default: d.axi.bresp = RESP_SLVERR;
            endcase
        end else if (q.axi.bvalid && axi_i.bready) begin
            d.axi.bvalid = 1'b0;
        end

        // AXI4-Lite read channel.
        if (axi_i.arvalid && q.axi.arready) begin
            d.axi.rvalid = 1'b1;
            d.axi.rresp  = RESP_OKAY;
            d.axi.rdata  = 32'h0000_0000;
            unique case (axi_i.araddr)
                OFS_PEND: d.axi.rdata[12:0] = q.pend;
                OFS_EN:   d.axi.rdata[12:0] = q.en;
                OFS_CTRL: begin
                    d.axi.rdata[CTRL_GIE_BIT]  = q.global_int_enable;
                    d.axi.rdata[CTRL_BUSY_BIT] = (q.st == VIA_ACK);
                end
                default:  d.axi.rresp = RESP_SLVERR;
            endcase
        end else if (q.axi.rvalid && axi_i.rready) begin
            d.axi.rvalid = 1'b0;
        end

        // Acknowledge sequencer.
        unique case (q.st)
            VIA_IDLE: begin
                if (return_from_int_instr_i) begin
                    d.global_int_enable     = 1'b1;
                    d.pc_load = 1'b1;
                    d.pc_addr = pop_addr_i;
                end else if (accept) begin
                    d.global_int_enable       = 1'b0;
                    d.trap_req  = trap_fetch_i;
                    d.push      = 1'b1;
                    d.push_addr = next_pc_i;
                    d.st        = VIA_ACK;
                    d.div       = 4'h0;
                    d.acks      = 3'h0;
                end
            end
            VIA_ACK: begin
                d.div = tick ? 4'h0 : q.div + 4'h1;
                if (tick) begin
                    d.acks = q.acks + 3'h1;
                    if (q.acks == 3'(ACK_INSTR_CYC - 1)) begin
                        d.pc_load = 1'b1;
                        d.pc_addr = ENTRY_ADDR;
                        d.st      = VIA_IDLE;
                    end
                end
            end
        endcase

        // Vector select: trap first, then the top-ranked active maskable source.
        if (vis_exec_i) begin
            slot = q.trap_pend ? SLOT_TRAP : top_slot(active);
            vis_blk = vis_pc_i[14:8] + 7'(vis_pc_i[7:0] == BLOCK_LAST);
            d.vis_valid = 1'b1;
            d.vis_low   = VEC_BASE + {3'h0, slot, 1'b0};
            d.vis_addr  = {vis_blk, d.vis_low};
        end

        d.axi.awready = ~d.aw_got & ~d.axi.bvalid;
        d.axi.wready  = ~d.w_got & ~d.axi.bvalid;
        d.axi.arready = ~d.axi.rvalid;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            q           <= '0;
            q.st        <= VIA_IDLE;
            q.pend      <= PEND_RST;
            q.en        <= EN_RST;
            q.global_int_enable       <= 1'b0;
            q.trap_pend <= 1'b0;
            q.axi       <= '0;
        end else begin
            q <= d;
        end
    end

    assign axi_o       = q.axi;
    assign ack_busy_o  = (q.st == VIA_ACK);
    assign gie_o       = q.global_int_enable;
    assign push_o      = q.push;
    assign push_addr_o = q.push_addr;
    assign pc_load_o   = q.pc_load;
    assign pc_addr_o   = q.pc_addr;
    assign vis_valid_o = q.vis_valid;
    assign vis_low_o   = q.vis_low;
    assign vis_addr_o  = q.vis_addr;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    localparam int ACK_CLKS_I = ACK_CLKS;
    logic [7:0] hc_r;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            hc_r <= 8'h00;
        end else begin
            hc_r <= (q.st == VIA_ACK) ? hc_r + 8'h01 : 8'h00;
        end
    end

    sequence take_s;
        accept;
    endsequence
    sequence pushed_s;
        push_o && !gie_o && push_addr_o == $past(next_pc_i);
    endsequence

    ack_push_gie_a : assert property (@(posedge clk_i) disable iff (rst_i)
        take_s |=> pushed_s)
        else $error("acknowledge did not clear enable and push");
    ack_length_a : assert property (@(posedge clk_i) disable iff (rst_i)
        pc_load_o && $past(q.st) == VIA_ACK |-> hc_r == 8'(ACK_CLKS_I) && pc_addr_o == ENTRY_ADDR)
        else $error("entry load not at seven instruction cycles");
    ack_entry_a : assert property (@(posedge clk_i) disable iff (rst_i)
        take_s |=> ack_busy_o [*8])
        else $error("acknowledge sequence ended early");
    mask_gate_a : assert property (@(posedge clk_i) disable iff (rst_i)
        accept && !q.trap_req |-> q.global_int_enable && !q.trap_pend)
        else $error("maskable taken while gated");
    skip_hold_a : assert property (@(posedge clk_i) disable iff (rst_i)
        instr_start_i && skip_i && !ack_busy_o |=> !push_o)
        else $error("acknowledge during skipped instruction");
    return_from_int_instr_restore_a : assert property (@(posedge clk_i) disable iff (rst_i)
        return_from_int_instr_i && !ack_busy_o |=> gie_o && pc_load_o && pc_addr_o == $past(pop_addr_i))
        else $error("return did not restore enable and address");
    vis_trap_a : assert property (@(posedge clk_i) disable iff (rst_i)
        vis_exec_i && q.trap_pend |=> vis_valid_o && vis_low_o == 8'hfe)
        else $error("trap not selected first");
    vis_default_a : assert property (@(posedge clk_i) disable iff (rst_i)
        vis_exec_i && !q.trap_pend && active == 13'h0000 |=> vis_low_o == VEC_BASE)
        else $error("default vector not used");
    pend_set_a : assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 (q.pend & $past(src_event_i)) == $past(src_event_i))
        else $error("pending event lost");
    trap_clear_a : assert property (@(posedge clk_i) disable iff (rst_i)
        clear_trap_i && !trap_fetch_i |=> !q.trap_pend)
        else $error("trap pending not cleared");
    vis_block_a : assert property (@(posedge clk_i) disable iff (rst_i)
        vis_exec_i && vis_pc_i[7:0] == 8'hff |=> vis_addr_o[14:8] == $past(vis_pc_i[14:8]) + 7'h01)
        else $error("vector table block wrong");

endmodule : via_core

// File: testbench/via_seq_model.sv
// CPU sequencer model that starts instructions for the interrupt arbiter.
`timescale 1ns/10ps
module via_seq_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        busy_i,
    input  wire logic        skip_req_i,
    input  wire logic [14:0] ret_pc_i,
    output logic             start_o,
    output logic             skip_o,
    output logic [14:0]      next_pc_o
);
    import via_pkg::*;

    logic [3:0] cnt_r;

    // Starts one instruction every instruction cycle and waits while the acknowledge runs.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_r   <= 4'h0;
            start_o <= 1'b0;
            skip_o  <= 1'b0;
        end else begin
            cnt_r   <= (busy_i || cnt_r == 4'(INSTR_CLKS - 1)) ? 4'h0 : cnt_r + 4'h1;
            start_o <= !busy_i && cnt_r == 4'(INSTR_CLKS - 1);
            skip_o  <= !busy_i && cnt_r == 4'(INSTR_CLKS - 1) && skip_req_i;
        end
    end

    // The return address is only valid with a start; otherwise the lines carry junk.
    assign next_pc_o = start_o ? ret_pc_i : ~ret_pc_i;
endmodule : via_seq_model

// File: testbench/tb_top.sv
// Self-checking testbench of the vectored interrupt arbiter.
`timescale 1ns/10ps
module tb_top;
    import via_pkg::*;
    logic         clk_i = 1'b0;
    logic         rst_i = 1'b1;
    logic         skip_req = 1'b0;
    via_axi_req_t axi_i = '0;
    via_axi_rsp_t axi_o;
    logic [12:0]  src_event_i = '0;
    logic         trap_fetch_i = 1'b0, clear_trap_i = 1'b0, return_from_int_instr_i = 1'b0, vis_exec_i = 1'b0;
    logic         instr_start_i, skip_i, ack_busy_o, gie_o, push_o, pc_load_o, vis_valid_o;
    logic [14:0]  next_pc_i, push_addr_o, pc_addr_o, vis_addr_o;
    logic [14:0]  ret_pc = '0, pop_addr_i = '0, vis_pc_i = '0;
    logic [7:0]   vis_low_o, gap = '0;
    logic [15:0]  seed = 16'h0016;
    logic         acking = 1'b0;
    logic [23:0]  q_push[$], q_load[$], q_vis[$];
    logic [33:0]  q_bus[$];
    int           num_errors = 0, checks = 0;

    via_core uut (.clk_i, .rst_i, .axi_i, .axi_o, .src_event_i, .trap_fetch_i,
        .clear_trap_i, .instr_start_i, .skip_i, .next_pc_i, .return_from_int_instr_i, .pop_addr_i,
        .vis_exec_i, .vis_pc_i, .ack_busy_o, .gie_o, .push_o, .push_addr_o,
        .pc_load_o, .pc_addr_o, .vis_valid_o, .vis_low_o, .vis_addr_o);
    via_seq_model seq (.clk_i, .rst_i, .busy_i(ack_busy_o), .skip_req_i(skip_req),
        .ret_pc_i(ret_pc), .start_o(instr_start_i), .skip_o(skip_i), .next_pc_o(next_pc_i));

    always #5 clk_i = ~clk_i;

    // ----------------------------------------
    // Checking and reporting
    // ----------------------------------------
    function automatic logic [15:0] rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed;
    endfunction : rnd

    task automatic give_verdict();
        if (num_errors == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : give_verdict

    task automatic tmo();
        num_errors++;
        give_verdict();
    endtask : tmo

    task automatic cmp_seq(input logic [23:0] e, input logic [23:0] g);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value at %0t: expected %h got %h", $time, e, g);
        end
    endtask : cmp_seq

    task automatic cmp_bus(input logic [33:0] e, input logic [33:0] g);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value at %0t: expected %h got %h", $time, e, g);
        end
    endtask : cmp_bus

    // Takes the oldest note of each kind whenever the design shows a result.
    always @(posedge clk_i) begin
        gap = push_o ? 8'h0 : gap + 8'h1;
        if (push_o) begin
            cmp_seq(q_push.size() != 0 ? q_push.pop_front() : '1, {9'h0, push_addr_o});
            acking = 1'b1;
        end
        if (pc_load_o) begin
            cmp_seq(q_load.size() != 0 ? q_load.pop_front() : '1,
                    {1'b0, acking ? gap : 8'h0, pc_addr_o});
            acking = 1'b0;
        end
        if (vis_valid_o)
            cmp_seq(q_vis.size() != 0 ? q_vis.pop_front() : '1, {1'b0, vis_low_o, vis_addr_o});
        if (axi_o.bvalid && axi_i.bready)
            cmp_bus(q_bus.size() != 0 ? q_bus.pop_front() : '1, {axi_o.bresp, 32'h0});
        if (axi_o.rvalid && axi_i.rready)
            cmp_bus(q_bus.size() != 0 ? q_bus.pop_front() : '1, {axi_o.rresp, axi_o.rdata});
    end

    // ----------------------------------------
    // Stimulus
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        @(posedge clk_i);
        q_bus.push_back({r, 32'h0});
        axi_i.awaddr  <= a;
        axi_i.wdata   <= d;
        axi_i.wstrb   <= 4'hf;
        axi_i.awvalid <= 1'b1;
        axi_i.wvalid  <= 1'b1;
        axi_i.bready  <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_i);
            if (axi_o.awready) axi_i.awvalid <= 1'b0;
            if (axi_o.wready) axi_i.wvalid <= 1'b0;
            if (axi_o.bvalid) break;
        end
        axi_i.bready <= 1'b0;
        if (n == 50) tmo();
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        int n;
        @(posedge clk_i);
        q_bus.push_back(e);
        axi_i.araddr  <= a;
        axi_i.arvalid <= 1'b1;
        axi_i.rready  <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_i);
            if (axi_o.arready) axi_i.arvalid <= 1'b0;
            if (axi_o.rvalid) break;
        end
        axi_i.rready <= 1'b0;
        if (n == 50) tmo();
    endtask : rd

    task automatic fire(input logic [12:0] m, input logic [3:0] f);
        @(posedge clk_i);
        src_event_i <= m;
        {trap_fetch_i, clear_trap_i, return_from_int_instr_i, vis_exec_i} <= f;
        @(posedge clk_i);
        src_event_i <= 13'h0;
        {trap_fetch_i, clear_trap_i, return_from_int_instr_i, vis_exec_i} <= 4'h0;
    endtask : fire

    task automatic settle(input int n);
        int i;
        for (i = 0; i < n; i++) begin
            if (q_push.size() + q_load.size() + q_vis.size() == 0) break;
            @(posedge clk_i);
        end
        if (i == n) tmo();
    endtask : settle

    task automatic ack_note();
        logic [14:0] p;
        p = 15'(rnd());
        ret_pc <= p;
        q_push.push_back({9'h0, p});
        q_load.push_back({1'b0, 8'(ACK_CLKS), ENTRY_ADDR});
    endtask : ack_note

    task automatic vector_select_instr(input logic [7:0] lo);
        logic [14:0] p;
        p = 15'(rnd());
        vis_pc_i <= p;
        q_vis.push_back({1'b0, lo, p[14:8] + 7'(p[7:0] == 8'hff), lo});
        fire(13'h0, 4'h1);
        settle(20);
    endtask : vector_select_instr

    initial begin
        int          k;
        logic [12:0] m;
        logic [14:0] pa;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rd(OFS_PEND, 34'h0);
        rd(OFS_EN, 34'h0);
        rd(OFS_CTRL, 34'h0);
        rd(8'h0c, {RESP_SLVERR, 32'h0});
        wr(8'h0c, 32'h1fff, RESP_SLVERR);
        fire(13'h0008, 4'h0);
        rd(OFS_PEND, {2'h0, 32'h8});
        vector_select_instr(VEC_BASE);
        wr(OFS_EN, 32'h1fff, RESP_OKAY);
        for (k = 0; k < NUM_SRC; k++) begin
            m = 13'(1 << k) | (13'(rnd()) & 13'((1 << k) - 1));
            wr(OFS_PEND, 32'h1fff, RESP_OKAY);
            fire(m, 4'h0);
            vector_select_instr(VEC_BASE + 8'(2 * k + 2));
        end
        wr(OFS_PEND, 32'h1fff, RESP_OKAY);
        fire(13'h0010, 4'h0);
        skip_req <= 1'b1;
        ack_note();
        wr(OFS_CTRL, 32'h1, RESP_OKAY);
        repeat (30) @(posedge clk_i);
        cmp_bus(34'(q_push.size()), 34'h1);
        skip_req <= 1'b0;
        settle(200);
        rd(OFS_CTRL, 34'h0);
        pa = 15'(rnd());
        pop_addr_i <= pa;
        q_load.push_back({9'h0, pa});
        ack_note();
        fire(13'h0, 4'h2);
        settle(200);
        wr(OFS_PEND, 32'h1fff, RESP_OKAY);
        wr(OFS_CTRL, 32'h1, RESP_OKAY);
        ack_note();
        fire(13'h0004, 4'h0);
        settle(200);
        wr(OFS_PEND, 32'h1fff, RESP_OKAY);
        ack_note();
        fire(13'h0, 4'h8);
        settle(200);
        fire(13'h0020, 4'h0);
        vector_select_instr(8'hfe);
        wr(OFS_CTRL, 32'h1, RESP_OKAY);
        repeat (40) @(posedge clk_i);
        ack_note();
        fire(13'h0, 4'h4);
        settle(200);
        vector_select_instr(VEC_BASE + 8'h0c);
        pa = {7'(rnd()), 8'hff};
        vis_pc_i <= pa;
        q_vis.push_back({1'b0, VEC_BASE + 8'h0c, pa[14:8] + 7'h01, VEC_BASE + 8'h0c});
        fire(13'h0, 4'h1);
        settle(20);
        give_verdict();
    end
endmodule : tb_top
